/* apit_pkg.sv */
package apit_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] APIT_IDX_CTL   = 16'h02F2;
  localparam logic [15:0] APIT_IDX_TRIM  = 16'h02F3;
  localparam logic [15:0] APIT_IDX_RATEH = 16'h02F4;
  localparam logic [15:0] APIT_IDX_RATEL = 16'h02F5;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          APIT_CTL_CLKSEL_BIT = 7;
  localparam int          APIT_CTL_ENABLE_BIT = 2;
  localparam int          APIT_CTL_IRQEN_BIT  = 1;
  localparam int          APIT_CTL_FLAG_BIT   = 0;
  localparam logic [5:0]  APIT_TRIM_RESET     = 6'h00;
  localparam logic [15:0] APIT_RATE_RESET     = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int APIT_CLK_FREQ_HZ      = 50000000;
  localparam int APIT_ACLK_FREQ_HZ     = 10000;
  localparam int APIT_ACLK_NOM_CYCLES  = APIT_CLK_FREQ_HZ / APIT_ACLK_FREQ_HZ;
  localparam int APIT_TRIM_STEP_CYCLES = 50;

  // ----------------------------------------------------------------
  // Configuration carried to the counter
  // ----------------------------------------------------------------
  typedef struct packed {
    logic clk_sel;
    logic enable;
    logic irq_en;
  } apit_cfg_t;

  function automatic logic [15:0] apit_byte_addr(input logic [15:0] idx);
    apit_byte_addr = {idx[13:0], 2'b00};
  endfunction

endpackage

/* apit_aclk_gen.sv */
`timescale 1ns/1ps
module apit_aclk_gen
  import apit_pkg::*;
#(
  parameter int NOM_CYCLES  = APIT_ACLK_NOM_CYCLES,
  parameter int STEP_CYCLES = APIT_TRIM_STEP_CYCLES
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Trim and tick
  input  wire logic [5:0] aclk_period_trim,
  output logic            aclk_tick
);

  logic [15:0] period_cycles;
  logic [15:0] phase;

  // A set top bit reads as negative, so subtracting lengthens the period.
  always_comb
  begin
    int p;
    p = NOM_CYCLES - int'($signed(aclk_period_trim)) * STEP_CYCLES;
    period_cycles = p[15:0];
  end

  // The oscillator runs free from reset; it never waits for the timer.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      phase     <= 16'h0000;
      aclk_tick <= 1'b0;
    end
    else if (phase >= period_cycles - 16'h0001)
    begin
      phase     <= 16'h0000;
      aclk_tick <= 1'b1;
    end
    else
    begin
      phase     <= phase + 16'h0001;
      aclk_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] gap;
  logic        trim_steady;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      gap         <= 16'h0000;
      trim_steady <= 1'b0;
    end
    else
    begin
      gap         <= aclk_tick ? 16'h0001 : gap + 16'h0001;
      trim_steady <= aclk_tick ? 1'b1 : trim_steady & (aclk_period_trim == $past(aclk_period_trim));
    end
  end

  AST_ACLK_TRIM_PERIOD: assert property (@(posedge clk) disable iff (!rst_b)
    aclk_tick && trim_steady && $stable(aclk_period_trim) && $past(trim_steady)
      |-> ##0 $past(aclk_tick) || gap == 16'(NOM_CYCLES - int'($signed(aclk_period_trim)) * STEP_CYCLES))
    else $error("Autonomous tick spacing does not match trim.");

endmodule // apit_aclk_gen

/* apit_period_cnt.sv */
`timescale 1ns/1ps
module apit_period_cnt
  import apit_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Configuration
  input  wire apit_cfg_t   cfg,
  input  wire logic [15:0] periodic_rate,
  input  wire logic        src_tick,
  // Event
  output logic             timeout
);

  logic [16:0] count;
  logic [16:0] terminal;

  assign terminal = {periodic_rate, 1'b1};

  always_ff @(posedge clk)
  begin
    if (!rst_b || !cfg.enable)
    begin
      count   <= 17'h00000;
      timeout <= 1'b0;
    end
    else if (src_tick && count == terminal)
    begin
      count   <= 17'h00000;
      timeout <= 1'b1;
    end
    else
    begin
      count   <= src_tick ? count + 17'h00001 : count;
      timeout <= 1'b0;
    end
  end

  AST_HELD_DISABLED: assert property (@(posedge clk) disable iff (!rst_b)
    !cfg.enable |=> count == 17'h00000 && !timeout)
    else $error("Counter moved while the feature was off.");

endmodule // apit_period_cnt

/* apit_top.sv */
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module apit_top
  import apit_pkg::*;
#(
  parameter int ACLK_NOM_CYCLES  = APIT_ACLK_NOM_CYCLES,
  parameter int TRIM_STEP_CYCLES = APIT_TRIM_STEP_CYCLES
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Non-volatile trim word
  input  wire logic [5:0]  nvm_trim_value,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  apit_cfg_t   cfg;
  logic        periodic_timeout_flag;
  logic [5:0]  aclk_period_trim;
  logic [15:0] periodic_rate;
  logic        trim_load_pending;
  logic        aclk_tick;
  logic        src_tick;
  logic        timeout;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic hit_ctl;
  logic hit_trim;
  logic hit_rateh;
  logic hit_ratel;
  logic mapped;
  logic access;
  logic wr;

  assign hit_ctl   = paddr == apit_byte_addr(APIT_IDX_CTL);
  assign hit_trim  = paddr == apit_byte_addr(APIT_IDX_TRIM);
  assign hit_rateh = paddr == apit_byte_addr(APIT_IDX_RATEH);
  assign hit_ratel = paddr == apit_byte_addr(APIT_IDX_RATEL);
  assign mapped    = hit_ctl | hit_trim | hit_rateh | hit_ratel;
  assign access    = psel & penable;
  assign wr        = access & pwrite & mapped;

  // Zero wait states: read data is fetched during the setup cycle.
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h00000000;
    end
    else if (psel && !penable && !pwrite)
    begin
      if (hit_ctl)
      begin
        prdata <= 32'({cfg.clk_sel, 4'h0, cfg.enable, cfg.irq_en, periodic_timeout_flag});
      end
      else if (hit_trim)
      begin
        prdata <= 32'({2'b00, aclk_period_trim});
      end
      else if (hit_rateh)
      begin
        prdata <= 32'(periodic_rate[15:8]);
      end
      else if (hit_ratel)
      begin
        prdata <= 32'(periodic_rate[7:0]);
      end
      else
      begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cfg <= '0;
    end
    else if (wr && hit_ctl)
    begin
      cfg.enable <= pwdata[APIT_CTL_ENABLE_BIT];
      cfg.irq_en <= pwdata[APIT_CTL_IRQEN_BIT];
      // Changing the source mid-run would give one period of mixed units.
      if (!cfg.enable && !pwdata[APIT_CTL_ENABLE_BIT])
      begin
        cfg.clk_sel <= pwdata[APIT_CTL_CLKSEL_BIT];
      end
    end
  end

  // A time-out in the same cycle as a write-one clear keeps the flag set.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      periodic_timeout_flag <= 1'b0;
    end
    else if (timeout)
    begin
      periodic_timeout_flag <= 1'b1;
    end
    else if (wr && hit_ctl && pwdata[APIT_CTL_FLAG_BIT])
    begin
      periodic_timeout_flag <= 1'b0;
    end
  end

  assign irq = periodic_timeout_flag & cfg.irq_en;

  // ----------------------------------------------------------------
  // Trim register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      trim_load_pending <= 1'b1;
    end
    else
    begin
      trim_load_pending <= 1'b0;
    end
  end

  // The stored word is sampled only after release, never under reset.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      aclk_period_trim <= APIT_TRIM_RESET;
    end
    else if (trim_load_pending)
    begin
      aclk_period_trim <= nvm_trim_value;
    end
    else if (wr && hit_trim)
    begin
      aclk_period_trim <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // Rate registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      periodic_rate <= APIT_RATE_RESET;
    end
    else if (wr && !cfg.enable)
    begin
      if (hit_rateh)
      begin
        periodic_rate[15:8] <= pwdata[7:0];
      end
      if (hit_ratel)
      begin
        periodic_rate[7:0] <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Timer datapath
  // ----------------------------------------------------------------
  apit_aclk_gen #(
    .NOM_CYCLES  (ACLK_NOM_CYCLES),
    .STEP_CYCLES (TRIM_STEP_CYCLES)
  ) u_aclk (
    .clk              (clk),
    .rst_b            (rst_b),
    .aclk_period_trim (aclk_period_trim),
    .aclk_tick        (aclk_tick)
  );

  assign src_tick = cfg.clk_sel ? 1'b1 : aclk_tick;

  apit_period_cnt u_cnt (
    .clk           (clk),
    .rst_b         (rst_b),
    .cfg           (cfg),
    .periodic_rate (periodic_rate),
    .src_tick      (src_tick),
    .timeout       (timeout)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [17:0] bus_gap;
  logic [17:0] tick_gap;
  logic [17:0] want_gap;

  assign want_gap = {1'b0, periodic_rate, 1'b0} + 18'h00002;

  always_ff @(posedge clk)
  begin
    if (!rst_b || !cfg.enable)
    begin
      bus_gap  <= 18'h00000;
      tick_gap <= 18'h00000;
    end
    else
    begin
      bus_gap  <= timeout ? 18'h00001 : bus_gap + 18'h00001;
      tick_gap <= timeout ? 18'(aclk_tick) : tick_gap + 18'(aclk_tick);
    end
  end

  AST_RATE_LOCKED: assert property (@(posedge clk) disable iff (!rst_b)
    cfg.enable && access && pwrite && (hit_rateh || hit_ratel) |=> $stable(periodic_rate))
    else $error("Rate changed while running.");

  AST_RATE_ACCEPT: assert property (@(posedge clk) disable iff (!rst_b)
    !cfg.enable && access && pwrite && hit_ratel |=> periodic_rate[7:0] == $past(pwdata[7:0]))
    else $error("Rate write lost while stopped.");

  AST_BUS_PERIOD: assert property (@(posedge clk) disable iff (!rst_b)
    timeout && cfg.clk_sel |-> bus_gap == want_gap)
    else $error("Bus-clock period wrong.");

  AST_ACLK_PERIOD: assert property (@(posedge clk) disable iff (!rst_b)
    timeout && !cfg.clk_sel |-> tick_gap == want_gap)
    else $error("Autonomous-clock period wrong.");

  AST_TRIM_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
    rst_b && trim_load_pending |=> aclk_period_trim == $past(nvm_trim_value))
    else $error("Trim not loaded after reset.");

  AST_TRIM_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    !trim_load_pending && access && pwrite && hit_trim |=> aclk_period_trim == $past(pwdata[5:0]))
    else $error("Trim write lost.");

  AST_CLKSEL_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
    access && pwrite && hit_ctl && (cfg.enable || pwdata[APIT_CTL_ENABLE_BIT]) |=> $stable(cfg.clk_sel))
    else $error("Clock select changed while enabled.");

  AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_b)
    timeout |=> periodic_timeout_flag)
    else $error("Time-out did not set the flag.");

  AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    periodic_timeout_flag && !timeout && access && pwrite && hit_ctl && pwdata[APIT_CTL_FLAG_BIT]
      |=> !periodic_timeout_flag ##1 (!irq || $past(timeout)))
    else $error("Write-one did not clear the flag.");

  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
    timeout && cfg.irq_en && !(wr && hit_ctl) |=> irq)
    else $error("Interrupt output mismatch.");

  // ----------------------------------------------------------------
  // Register write checks
  // ----------------------------------------------------------------
  // Each check but AST_TRIM_LOAD_ONCE and AST_TIMEOUT_PULSE pins down one side of a write: what must land and what must stay put.
  AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    periodic_timeout_flag && !(wr && hit_ctl && pwdata[APIT_CTL_FLAG_BIT]) |=> periodic_timeout_flag)
    else $error("Flag dropped without a write-one.");

  AST_CLKSEL_OPEN: assert property (@(posedge clk) disable iff (!rst_b)
    !cfg.enable && wr && hit_ctl && !pwdata[APIT_CTL_ENABLE_BIT]
      |=> cfg.clk_sel == $past(pwdata[APIT_CTL_CLKSEL_BIT]))
    else $error("Clock select write lost while stopped.");

  AST_ENABLE_START: assert property (@(posedge clk) disable iff (!rst_b)
    wr && hit_ctl && pwdata[APIT_CTL_ENABLE_BIT] |=> cfg.enable)
    else $error("Enable write did not start the timer.");

  AST_RATE_HIGH_ACCEPT: assert property (@(posedge clk) disable iff (!rst_b)
    !cfg.enable && wr && hit_rateh |=> periodic_rate[15:8] == $past(pwdata[7:0]))
    else $error("Rate high write lost while stopped.");

  AST_TRIM_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !trim_load_pending && !(wr && hit_trim) |=> $stable(aclk_period_trim))
    else $error("Trim changed without a write.");

  AST_TRIM_LOAD_ONCE: assert property (@(posedge clk) disable iff (!rst_b)
    rst_b && trim_load_pending |=> !trim_load_pending)
    else $error("Trim load repeated.");

  AST_TIMEOUT_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    timeout |=> !timeout)
    else $error("Time-out held for two cycles.");

  // The stored trim word may still be landing in the first cycle after release.
  AST_UNMAPPED_QUIET: assert property (@(posedge clk) disable iff (!rst_b)
    !trim_load_pending && access && pwrite && !mapped
      |=> $stable(cfg) && $stable(aclk_period_trim) && $stable(periodic_rate))
    else $error("Unmapped write changed a register.");

endmodule // apit_top

/* apit_tb.sv */
`timescale 1ns/1ps
module apit_tb
  import apit_pkg::*;
;
  // ----------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------
  localparam int          NOM     = 200;
  localparam int          STEP    = 2;
  localparam int          CEILING = 20000;
  localparam logic [5:0]  NVM     = 6'h15;
  localparam logic [15:0] A_CTL   = {APIT_IDX_CTL[13:0], 2'b00};
  localparam logic [15:0] A_TRIM  = {APIT_IDX_TRIM[13:0], 2'b00};
  localparam logic [15:0] A_RH    = {APIT_IDX_RATEH[13:0], 2'b00};
  localparam logic [15:0] A_RL    = {APIT_IDX_RATEL[13:0], 2'b00};
  localparam logic [15:0] A_BAD   = 16'h0BD8;

  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  nvm_trim_value;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          n_fail      = 0;
  int          comparisons = 0;
  int          cyc         = 0;

  apit_top #(.ACLK_NOM_CYCLES(NOM), .TRIM_STEP_CYCLES(STEP)) uut (
    .clk            (clk),
    .rst_b          (rst_b),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .nvm_trim_value (nvm_trim_value),
    .irq            (irq)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc >= CEILING)
    begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic wait_irq(output int t);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (irq !== 1'b1 && n < 3000);
    t = cyc;
    chk("irq set", 32'h1, {31'h0, irq});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    rdchk("ctl reset", A_CTL, 32'h0);
    rdchk("rate high reset", A_RH, 32'h0);
    rdchk("rate low reset", A_RL, 32'h0);
    rdchk("trim load", A_TRIM, {26'h0, NVM});
    apb(1'b1, A_BAD, 32'hFF);
    chk("unmapped err", 32'h1, {31'h0, err});
    rdchk("unmapped data", A_BAD, 32'h0);
    chk("irq idle", 32'h0, {31'h0, irq});
    $display("test_reset done");
  endtask

  task automatic test_trim();
    apb(1'b1, A_TRIM, 32'h2A);
    rdchk("trim rw", A_TRIM, 32'h2A);
    apb(1'b1, A_TRIM, 32'hFF);
    rdchk("trim width", A_TRIM, 32'h3F);
    apb(1'b1, A_CTL, 32'h04);
    apb(1'b1, A_TRIM, 32'h11);
    rdchk("trim while running", A_TRIM, 32'h11);
    apb(1'b1, A_CTL, 32'h00);
    $display("test_trim done");
  endtask

  task automatic test_rate_lock();
    apb(1'b1, A_RH, 32'h12);
    apb(1'b1, A_RL, 32'h34);
    rdchk("rate high idle", A_RH, 32'h12);
    rdchk("rate low idle", A_RL, 32'h34);
    apb(1'b1, A_CTL, 32'h84);
    rdchk("clksel with enable", A_CTL, 32'h04);
    apb(1'b1, A_RH, 32'hAB);
    apb(1'b1, A_RL, 32'hCD);
    rdchk("rate high locked", A_RH, 32'h12);
    rdchk("rate low locked", A_RL, 32'h34);
    apb(1'b1, A_CTL, 32'h86);
    rdchk("clksel locked", A_CTL, 32'h06);
    apb(1'b1, A_CTL, 32'h00);
    apb(1'b1, A_CTL, 32'h80);
    rdchk("clksel idle", A_CTL, 32'h80);
    apb(1'b1, A_RH, 32'h01);
    apb(1'b1, A_RL, 32'h00);
    rdchk("rate reopened", A_RH, 32'h01);
    $display("test_rate_lock done");
  endtask

  task automatic test_bus_period();
    int p;
    int t0;
    int t1;
    int t2;
    p = 2 * (16'h0100 + 1);
    apb(1'b1, A_CTL, 32'h86);
    t0 = cyc;
    wait_irq(t1);
    chk("first timeout", 32'(p + 2), 32'(t1 - t0));
    apb(1'b1, A_CTL, 32'h86);
    rdchk("flag write zero", A_CTL, 32'h87);
    apb(1'b1, A_CTL, 32'h87);
    rdchk("flag cleared", A_CTL, 32'h86);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wait_irq(t2);
    chk("bus period", 32'(p), 32'(t2 - t1));
    apb(1'b1, A_CTL, 32'h84);
    rdchk("flag kept masked", A_CTL, 32'h85);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, A_CTL, 32'h81);
    repeat (2 * p) @(posedge clk);
    rdchk("no timeout disabled", A_CTL, 32'h80);
    apb(1'b1, A_CTL, 32'h86);
    t0 = cyc;
    wait_irq(t1);
    chk("restart from zero", 32'(p + 2), 32'(t1 - t0));
    apb(1'b1, A_CTL, 32'h81);
    $display("test_bus_period done");
  endtask

  task automatic test_aclk_period();
    logic [5:0] tv [4] = '{6'h00, 6'h20, 6'h1F, 6'h10};
    int         s;
    int         t1;
    int         t2;
    apb(1'b1, A_CTL, 32'h00);
    apb(1'b1, A_RH, 32'h00);
    apb(1'b1, A_RL, 32'h01);
    for (int i = 0; i < 4; i++)
    begin
      s = $signed(tv[i]);
      apb(1'b1, A_TRIM, {26'h0, tv[i]});
      apb(1'b1, A_CTL, 32'h06);
      wait_irq(t1);
      apb(1'b1, A_CTL, 32'h07);
      wait_irq(t2);
      chk("aclk period", 32'(4 * (NOM - s * STEP)), 32'(t2 - t1));
      apb(1'b1, A_CTL, 32'h01);
    end
    $display("test_aclk_period done");
  endtask

  task automatic test_reload();
    @(posedge clk);
    nvm_trim_value <= 6'h2B;
    rst_b          <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rdchk("trim reload", A_TRIM, 32'h2B);
    nvm_trim_value <= 6'h0A;
    rdchk("trim loaded once", A_TRIM, 32'h2B);
    rdchk("ctl after reset", A_CTL, 32'h0);
    $display("test_reload done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_b          = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 16'h0000;
    pwdata         = 32'h0;
    nvm_trim_value = NVM;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    test_reset();
    test_trim();
    test_rate_lock();
    test_bus_period();
    test_aclk_period();
    test_reload();
    final_report();
  end
endmodule // apit_tb
